//--- curtain_strap_pkg.sv
// Purpose: Shared constants and types for the light-curtain strap decoder.
// Assumes: 40 MHz system clock, APB register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
package curtain_strap_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DELAY_SHORT_MS = 100;
  localparam int unsigned DELAY_LONG_MS = 500;
  localparam int unsigned DELAY_SHORT_CYC = DELAY_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_LONG_CYC = DELAY_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_CNT_W = 25;
  localparam int unsigned SETTLE_CYC = 4;
  localparam int unsigned SYNC_W = 10;

  // Register map
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] LINK_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // Interrupt status bit positions
  localparam int unsigned EV_CFG_DONE = 0;
  localparam int unsigned EV_CFG_FAULT = 1;
  localparam int unsigned EV_INTERFERE = 2;
  localparam int unsigned EV_DELAY_DONE = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  // Link register field positions
  localparam int unsigned LNK_DELAY_SEL = 0;
  localparam int unsigned LNK_INTERFERE = 1;
  localparam int unsigned LNK_DELAY_DONE = 2;
  localparam int unsigned LNK_CODE_LSB = 4;

  // Mode numbers as seen by software; zero means no muting mode
  localparam logic [2:0] MODE_NONE = 3'h0;

  typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_RUN, ST_FAULT} start_state_t;

  // Raw strap levels and bridges seen on the plug
  typedef struct packed {
    logic p2High;
    logic p7High;
    logic p3High;
    logic p4High;
    logic bridge4;
    logic bridge8;
    logic bridge3;
  } strap_t;

  // Decoded start-up configuration
  typedef struct packed {
    logic fault;
    logic [2:0] mode;
    logic edmOn;
    logic resOn;
    logic seqMuting;
    logic fourSensor;
    logic longTimeout;
    logic extAllowed;
    logic enableAllowed;
    logic partialAllowed;
  } config_t;

  localparam config_t CONFIG_RST = '0;

endpackage : curtain_strap_pkg

//--- pin_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes: Inputs are slow levels; no bus coherency across bits is needed.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] pinRaw,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;

  // A zero-width group has nothing to carry, refused at elaboration
  if (WIDTH < 1) begin : bad_width_g
    $error("pin_sync WIDTH must be at least 1");
  end

  // Two flops in series, reset to all low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage1 <= '0;
      pinSync <= '0;
    end else if (ce) begin
      stage1 <= pinRaw;
      pinSync <= stage1;
    end
  end

endmodule : pin_sync

//--- safety_curtain_mode_strap_decoder.sv
// Purpose: Start-up strap decoding, restart delay and bus parameter bits.
// Assumes: Strap and button pins are asynchronous; bus-side inputs share clk_sys.
// Notes: Straps are sampled once after reset; a new setting needs a restart.
//
// Functional notes
// [R1] Restart delay 100 ms, or 500 ms if selected.
// [R2] Master writes interference bit 1, then reads.
// [R3] Interference bit stays 1 without interference.
// [R4] Fault or interference clears interference bit; here only interferenceDetect clears it.
// [R5] Parameter bits never drive safety decisions.
// [R6] Muting indicator follows bus output bit 0.
// [R7] Safe code sequence on input bits 0-3.
// [R8] Feedback pin high disables contactor check.
// [R9] Non-muting: bridge disables, high enables interlock.
// [R10] Restart request taken from restart pin.
// [R11] Muting models keep restart interlock always on.
// [R12] Polarity and bridge select muting modes 1-6.
// [R13] Long timeout in modes 2, 4 only.
// [R14] Sequence muting modes 3, 4; else timing.
// [R15] Contactor check only in modes 1,2,3,5.
// [R16] Options: extension 1,5,6; enable 5; partial 6.
// [R17] Second muting input from socket or plug.
// [R18] Straps sampled once at start-up only.
// [R19] Unknown strap combination gives fault, outputs off.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module safety_curtain_mode_strap_decoder
  import curtain_strap_pkg::*;
#(
  parameter bit MUTING_MODEL = 1'b1,
  parameter bit EIGHT_PIN_SOCKET = 1'b0,
  parameter int unsigned SHORT_DELAY_CYC = curtain_strap_pkg::DELAY_SHORT_CYC,
  parameter int unsigned LONG_DELAY_CYC = curtain_strap_pkg::DELAY_LONG_CYC
) (
  // Clocking
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Plug and socket pins, asynchronous
  input wire curtain_strap_pkg::strap_t strapPins,
  input wire logic restartPin,
  input wire logic plugMs2Pin,
  input wire logic socketMs2Pin,
  // Safety bus side, same clock
  input wire logic paramWrite,
  input wire logic [1:0] paramWriteData,
  input wire logic [3:0] busOutData,
  input wire logic [3:0] codeWord,
  input wire logic interferenceDetect,
  input wire logic beamInterrupted,
  // Parameter and data bits towards the bus
  output logic restartDelaySelect,
  output logic interferenceFlag,
  output logic indicatorOutputBit,
  output logic [3:0] safeCodeInputs,
  // Decoded configuration and run status
  output curtain_strap_pkg::config_t cfg,
  output logic safetyOutputsEnable,
  output logic restartDelayDone,
  output logic restartRequest,
  output logic secondMutingInput
);

  // Counts that the delay counter cannot hold are refused at elaboration
  if (SHORT_DELAY_CYC < 1 || LONG_DELAY_CYC < SHORT_DELAY_CYC ||
      LONG_DELAY_CYC >= (1 << DELAY_CNT_W)) begin : bad_delay_g
    $error("restart delay counts out of range");
  end

  // Mode number to configuration; used only by the strap decode
  function automatic config_t modeConfig(input logic [2:0] m, input logic edmPin);
    config_t c;
    c = CONFIG_RST;
    c.mode = m;
    c.resOn = 1'b1; // R11
    c.seqMuting = (m == 3'h3) || (m == 3'h4); // R14
    c.fourSensor = !c.seqMuting && EIGHT_PIN_SOCKET; // R14
    c.longTimeout = (m == 3'h2) || (m == 3'h4); // R13
    c.edmOn = !edmPin && (m != 3'h4) && (m != 3'h6); // R15
    c.extAllowed = (m == 3'h1) || (m == 3'h5) || (m == 3'h6); // R16
    c.enableAllowed = (m == 3'h5); // R16
    c.partialAllowed = (m == 3'h6); // R16
    return c;
  endfunction : modeConfig

  // Strap combination to configuration, fault on anything unlisted
  function automatic config_t decodeStraps(input strap_t s);
    config_t c;
    logic [2:0] bridges;
    c = CONFIG_RST;
    bridges = {s.bridge4, s.bridge8, s.bridge3};
    if (!MUTING_MODEL) begin
      c.edmOn = !s.p3High; // R8
      if (s.bridge4 && !s.p4High && !s.bridge8 && !s.bridge3)
        c.resOn = 1'b0; // R9
      else if (s.p4High && bridges == 3'h0)
        c.resOn = 1'b1; // R9
      else
        c.fault = 1'b1; // R19
    end else if (s.p2High && !s.p7High) begin
      case (bridges) // R12
        3'h4: c = modeConfig(3'h1, s.p3High);
        3'h2: c = modeConfig(3'h2, s.p3High);
        3'h1: c = modeConfig(3'h4, s.p3High);
        default: c.fault = 1'b1; // R19
      endcase
    end else if (!s.p2High && s.p7High) begin
      case (bridges) // R12
        3'h2: c = modeConfig(3'h3, s.p3High);
        3'h4: c = modeConfig(3'h5, s.p3High);
        3'h1: c = modeConfig(3'h6, s.p3High);
        default: c.fault = 1'b1; // R19
      endcase
    end else begin
      c.fault = 1'b1; // R19
    end
    return c;
  endfunction : decodeStraps

  // Synchronised pins
  strap_t strapSync;
  logic restartSync;
  logic plugMs2Sync;
  logic socketMs2Sync;

  pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .pinRaw({strapPins, restartPin, plugMs2Pin, socketMs2Pin}),
    .pinSync({strapSync, restartSync, plugMs2Sync, socketMs2Sync})
  );

  start_state_t state;
  logic [2:0] settleCnt;
  logic [DELAY_CNT_W-1:0] delayCnt;
  logic delayArmed;
  logic [EV_W-1:0] irqStat;
  logic [EV_W-1:0] irqMask;
  logic [EV_W-1:0] events;
  logic apbSetup;
  logic apbAccess;
  logic cfgDoneEv;
  logic cfgFaultEv;
  logic interfereEv;
  logic delayDoneEv;
  logic [DELAY_CNT_W-1:0] delayTarget;
  config_t sampleCfg;

  assign apbSetup = psel && !penable;
  assign apbAccess = psel && penable && pready;

  // Start-up sequence: let the synchronisers fill, then sample exactly once
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_SETTLE;
      settleCnt <= '0;
      cfg <= CONFIG_RST;
    end else if (ce) begin
      case (state)
        ST_SETTLE: begin
          settleCnt <= settleCnt + 3'h1;
          if (settleCnt == 3'(SETTLE_CYC - 1)) state <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          cfg <= sampleCfg; // R18
          state <= sampleCfg.fault ? ST_FAULT : ST_RUN; // R19
        end
        ST_RUN: state <= ST_RUN; // Straps are no longer looked at R18
        ST_FAULT: state <= ST_FAULT; // Only a reset leaves the fault R19
        default: state <= ST_FAULT;
      endcase
    end
  end

  // One decode of the synchronised straps, used by the sampler and the events
  assign sampleCfg = decodeStraps(strapSync);
  assign cfgDoneEv = ce && (state == ST_SAMPLE);
  assign cfgFaultEv = cfgDoneEv && sampleCfg.fault;

  // Safety outputs may only switch on from a valid configuration
  always_ff @(posedge clk_sys) begin
    if (!rst_b) safetyOutputsEnable <= 1'b0;
    else if (ce) safetyOutputsEnable <= (state == ST_RUN); // R19
  end

  // Parameter bits from the bus master; APB cannot reach them
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      restartDelaySelect <= 1'b0;
      interferenceFlag <= 1'b0;
    end else if (ce) begin
      if (paramWrite) restartDelaySelect <= paramWriteData[0]; // R5
      // A detection in the write cycle wins: the master must not see a clean 1
      if (interferenceDetect) interferenceFlag <= 1'b0; // R4
      else if (paramWrite && paramWriteData[1]) interferenceFlag <= 1'b1; // R2 R3
    end
  end

  assign interfereEv = ce && interferenceDetect && interferenceFlag;

  // Plain bus data: indicator bit out, safe code sequence in
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      indicatorOutputBit <= 1'b0;
      safeCodeInputs <= 4'h0;
    end else if (ce) begin
      indicatorOutputBit <= busOutData[0]; // R6
      safeCodeInputs <= codeWord; // R7
    end
  end

  // Button and muting inputs, gated by the run state; the button also by the decoded configuration
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      restartRequest <= 1'b0;
      secondMutingInput <= 1'b0;
    end else if (ce) begin
      restartRequest <= (state == ST_RUN) && cfg.resOn && restartSync; // R10
      secondMutingInput <= (state == ST_RUN) && MUTING_MODEL &&
        (plugMs2Sync || socketMs2Sync); // R17
    end
  end

  // Delay length is latched when the beam clears, so a later change waits
  assign delayTarget = restartDelaySelect ? DELAY_CNT_W'(LONG_DELAY_CYC - 1) :
    DELAY_CNT_W'(SHORT_DELAY_CYC - 1);

  // Restart delay after a beam interruption
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      delayCnt <= '0;
      delayArmed <= 1'b0;
      restartDelayDone <= 1'b0;
    end else if (ce) begin
      if (beamInterrupted) begin
        delayCnt <= delayTarget; // R1
        delayArmed <= 1'b1;
        restartDelayDone <= 1'b0;
      end else if (delayArmed) begin
        if (delayCnt == '0) begin
          delayArmed <= 1'b0;
          restartDelayDone <= 1'b1; // R1
        end else begin
          delayCnt <= delayCnt - DELAY_CNT_W'(1);
        end
      end
    end
  end

  assign delayDoneEv = ce && delayArmed && !beamInterrupted && (delayCnt == '0);
  assign events = {delayDoneEv, interfereEv, cfgFaultEv, cfgDoneEv};

  // Sticky status, cleared by an APB read; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) irqStat <= '0;
    else if (ce) begin
      // Clear only what the read returned; an event in the setup cycle survives
      if (apbAccess && !pwrite && paddr == IRQ_STAT_OFS)
        irqStat <= (irqStat & ~prdata[EV_W-1:0]) | events;
      else irqStat <= irqStat | events;
    end
  end

  // Mask register write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) irqMask <= IRQ_MASK_RST;
    else if (ce && apbAccess && pwrite && paddr == IRQ_MASK_OFS) irqMask <= pwdata[EV_W-1:0];
  end

  // Interrupt level, one cycle behind the status
  always_ff @(posedge clk_sys) begin
    if (!rst_b) irq <= 1'b0;
    else if (ce) irq <= |(irqStat & irqMask);
  end

  // APB: read data prepared in setup, pready high in the access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apbSetup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apbSetup) begin
        case (paddr)
          CONFIG_OFS: prdata <= {20'h0, state == ST_RUN, 11'(cfg)};
          LINK_OFS: prdata <= {24'h0, safeCodeInputs, 1'b0, restartDelayDone,
                               interferenceFlag, restartDelaySelect};
          IRQ_STAT_OFS: prdata <= {28'h0, irqStat};
          IRQ_MASK_OFS: prdata <= {28'h0, irqMask};
          default: pslverr <= 1'b1; // Unmapped address
        endcase
        // Only the mask is writable
        if (pwrite && paddr != IRQ_MASK_OFS) pslverr <= 1'b1;
      end
    end
  end

  // Checks
  cfg_once_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_RUN || state == ST_FAULT) |=> $stable(cfg)) // R18
    else $error("configuration changed after start-up");
  fault_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg.fault && state == ST_FAULT |=> !safetyOutputsEnable) // R19
    else $error("safety outputs on in fault state");
  interfere_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce && interferenceDetect |=> !interferenceFlag) // R4
    else $error("interference bit not cleared");
  interfere_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce && interferenceFlag && !interferenceDetect |=> interferenceFlag) // R3
    else $error("interference bit dropped without cause");
  indicator_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce |=> indicatorOutputBit == $past(busOutData[0])) // R6
    else $error("indicator does not follow bus bit 0");
  code_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce |=> safeCodeInputs == $past(codeWord)) // R7
    else $error("safe code not presented");
  muting_res_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    MUTING_MODEL && state == ST_RUN |-> cfg.resOn) // R11
    else $error("restart interlock off in muting mode");
  edm_modes_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    MUTING_MODEL && (cfg.mode == 3'h4 || cfg.mode == 3'h6) |-> !cfg.edmOn) // R15
    else $error("contactor check on in mode 4 or 6");
  timeout_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == ST_RUN && MUTING_MODEL |->
    cfg.longTimeout == (cfg.mode == 3'h2 || cfg.mode == 3'h4)) // R13
    else $error("muting timeout does not match mode");
  delay_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce && beamInterrupted ##1 ce && !beamInterrupted |-> !restartDelayDone) // R1
    else $error("restart released without delay");
  restart_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    restartRequest |-> cfg.resOn && state == ST_RUN) // R10
    else $error("restart request without interlock");

  run_c: cover property (@(posedge clk_sys) disable iff (!rst_b) state == ST_RUN);
  fault_c: cover property (@(posedge clk_sys) disable iff (!rst_b) state == ST_FAULT);
  delay_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(restartDelayDone));
  interfere_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(interferenceFlag));

endmodule : safety_curtain_mode_strap_decoder

//--- asi_master_model.sv
// Purpose: Behavioural safety-bus master driving the parameter port and data bits.
// Assumes: Shares clk_sys with the decoder; all changes land just after a rising edge.
// Notes: Beam and disturbance sources live here too, as the bus side of the receiver.
`timescale 1ns/10ps
module asi_master_model (
  // Clocking
  input wire logic clk_sys,
  // Bus side towards the decoder
  output logic paramWrite,
  output logic [1:0] paramWriteData,
  output logic [3:0] busOutData,
  output logic [3:0] codeWord,
  output logic interferenceDetect,
  output logic beamInterrupted
);
  // Idle values at time zero
  initial begin
    paramWrite = 1'b0;
    paramWriteData = 2'b00;
    busOutData = 4'h0;
    codeWord = 4'h0;
    interferenceDetect = 1'b0;
    beamInterrupted = 1'b0;
  end

  // Parameter call; only this master touches the port, data scrambled once released
  task automatic param_call(input logic [1:0] d);
    @(posedge clk_sys);
    paramWrite <= 1'b1;
    paramWriteData <= d;
    @(posedge clk_sys);
    paramWrite <= 1'b0;
    paramWriteData <= ~d;
  endtask : param_call

  // One-cycle periphery disturbance
  task automatic disturb;
    @(posedge clk_sys);
    interferenceDetect <= 1'b1;
    @(posedge clk_sys);
    interferenceDetect <= 1'b0;
  endtask : disturb

  // Beam broken for a number of cycles
  task automatic beam_cut(input int n);
    @(posedge clk_sys);
    beamInterrupted <= 1'b1;
    repeat (n) @(posedge clk_sys);
    beamInterrupted <= 1'b0;
  endtask : beam_cut

  // New output word and safe code nibble
  task automatic send_data(input logic [3:0] o, input logic [3:0] c);
    @(posedge clk_sys);
    busOutData <= o;
    codeWord <= c;
  endtask : send_data
endmodule : asi_master_model

//--- safety_curtain_mode_strap_decoder_test.sv
// Purpose: Self-checking bench for strap decoding, parameter bits and registers.
// Assumes: Delays shortened to 8 and 20 cycles; clock enable dropped once.
// Notes: Each strap setting needs its own reset, since straps are read once.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module safety_curtain_mode_strap_decoder_test;
  import curtain_strap_pkg::*;
  localparam int SHORT = 8;
  localparam int LONG = 20;
  typedef struct packed {strap_t s; logic [2:0] m;} row_t;
  logic clk_sys, rst_b, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, restartPin, plugMs2Pin, socketMs2Pin;
  logic paramWrite, interferenceDetect, beamInterrupted;
  logic [1:0] paramWriteData;
  logic [3:0] busOutData, codeWord, safeCodeInputs;
  logic restartDelaySelect, interferenceFlag, indicatorOutputBit;
  logic safetyOutputsEnable, restartDelayDone, restartRequest, secondMutingInput;
  strap_t strapPins;
  config_t cfg, nmCfg, ec;
  int errors = 0;
  int comparisons = 0;
  // Fault rows first so the last row leaves a valid mode running
  row_t rows[9] = '{'{7'b1000110, 3'h0}, '{7'b1100100, 3'h0}, '{7'b1010010, 3'h2},
    '{7'b0100010, 3'h3}, '{7'b1000001, 3'h4}, '{7'b0100100, 3'h5}, '{7'b0100001, 3'h6},
    '{7'b1010100, 3'h1}, '{7'b1001100, 3'h1}};

  // Muting model under test
  safety_curtain_mode_strap_decoder #(.SHORT_DELAY_CYC(SHORT), .LONG_DELAY_CYC(LONG))
    safety_curtain_mode_strap_decoder_i (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .strapPins(strapPins),
    .restartPin(restartPin), .plugMs2Pin(plugMs2Pin), .socketMs2Pin(socketMs2Pin),
    .paramWrite(paramWrite), .paramWriteData(paramWriteData), .busOutData(busOutData),
    .codeWord(codeWord), .interferenceDetect(interferenceDetect),
    .beamInterrupted(beamInterrupted), .restartDelaySelect(restartDelaySelect),
    .interferenceFlag(interferenceFlag), .indicatorOutputBit(indicatorOutputBit),
    .safeCodeInputs(safeCodeInputs), .cfg(cfg), .safetyOutputsEnable(safetyOutputsEnable),
    .restartDelayDone(restartDelayDone), .restartRequest(restartRequest),
    .secondMutingInput(secondMutingInput));

  // Non-muting model on the same wiring, only its decode is watched
  safety_curtain_mode_strap_decoder #(.MUTING_MODEL(1'b0)) safety_curtain_mode_strap_decoder_nm_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(),
    .strapPins(strapPins), .restartPin(restartPin), .plugMs2Pin(plugMs2Pin),
    .socketMs2Pin(socketMs2Pin), .paramWrite(paramWrite), .paramWriteData(paramWriteData),
    .busOutData(busOutData), .codeWord(codeWord), .interferenceDetect(interferenceDetect),
    .beamInterrupted(beamInterrupted), .restartDelaySelect(), .interferenceFlag(),
    .indicatorOutputBit(), .safeCodeInputs(), .cfg(nmCfg), .safetyOutputsEnable(),
    .restartDelayDone(), .restartRequest(), .secondMutingInput());

  asi_master_model asi_master_model_i (.clk_sys(clk_sys), .paramWrite(paramWrite),
    .paramWriteData(paramWriteData), .busOutData(busOutData), .codeWord(codeWord),
    .interferenceDetect(interferenceDetect), .beamInterrupted(beamInterrupted));

  // Clock, 25 ns period
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Expected decode of one muting mode
  function automatic config_t exp_cfg(input logic [2:0] m, input logic p3);
    config_t c;
    c = CONFIG_RST;
    c.mode = m;
    c.resOn = 1'b1;
    c.edmOn = !p3 && (m inside {3'h1, 3'h2, 3'h3, 3'h5});
    c.seqMuting = m inside {3'h3, 3'h4};
    c.longTimeout = m inside {3'h2, 3'h4};
    c.extAllowed = m inside {3'h1, 3'h5, 3'h6};
    c.enableAllowed = (m == 3'h5);
    c.partialAllowed = (m == 3'h6);
    return c;
  endfunction : exp_cfg

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset with a new strap setting, then let start-up finish
  task automatic do_reset(input strap_t s);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    strapPins <= s;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : do_reset

  // Restart delay after a short interruption, selected by the parameter bit
  task automatic check_delay(input logic [1:0] d, input int cyc);
    int k;
    asi_master_model_i.param_call(d);
    @(negedge clk_sys);
    `CHK(restartDelaySelect, d[0])
    asi_master_model_i.beam_cut(3);
    `CHK(restartDelayDone, 1'b0)
    k = 0;
    while (restartDelayDone !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(k >= cyc && k <= cyc + 3, 1'b1)
  endtask : check_delay

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strapPins = '0;
    restartPin = 1'b0;
    plugMs2Pin = 1'b0;
    socketMs2Pin = 1'b0;
    repeat (20) @(posedge clk_sys);
    // Table of strap settings
    foreach (rows[k]) begin
      do_reset(rows[k].s);
      ec = exp_cfg(rows[k].m, rows[k].s.p3High);
      if (rows[k].m == MODE_NONE) begin
        `CHK(cfg.fault, 1'b1)
        `CHK(safetyOutputsEnable, 1'b0)
      end else begin
        `CHK(cfg, ec)
        `CHK(cfg.edmOn, ec.edmOn)
        `CHK(cfg.resOn, 1'b1)
        `CHK(cfg.longTimeout, ec.longTimeout)
        `CHK({cfg.seqMuting, cfg.fourSensor}, {ec.seqMuting, 1'b0})
        `CHK(cfg.edmOn && !(cfg.mode inside {3'h4, 3'h6}), cfg.edmOn)
        `CHK({cfg.extAllowed, cfg.enableAllowed, cfg.partialAllowed}, ec[2:0])
        `CHK(safetyOutputsEnable, 1'b1)
        apb(CONFIG_OFS, 1'b0, 32'h0);
        `CHK(rd[11:0], {1'b1, ec[10:0]})
      end
    end
    // Strap change while running is ignored
    strapPins <= 7'b0100001;
    repeat (10) @(posedge clk_sys);
    `CHK(cfg, ec)
    // Restart button and second muting input
    restartPin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK(restartRequest, 1'b1)
    restartPin <= 1'b0;
    socketMs2Pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK({restartRequest, secondMutingInput}, 2'b01)
    socketMs2Pin <= 1'b0;
    plugMs2Pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK(secondMutingInput, 1'b1)
    plugMs2Pin <= 1'b0;
    // Indicator bit and safe code nibble
    for (int v = 0; v < 16; v += 5) begin
      asi_master_model_i.send_data(v[3:0], ~v[3:0]);
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(indicatorOutputBit, v[0])
      `CHK(safeCodeInputs, ~v[3:0])
    end
    // Clock enable low freezes the data bits, high lets them follow again
    @(posedge clk_sys);
    ce <= 1'b0;
    asi_master_model_i.send_data(4'h0, 4'h5);
    repeat (3) @(posedge clk_sys);
    `CHK({indicatorOutputBit, safeCodeInputs}, 5'h10)
    ce <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({indicatorOutputBit, safeCodeInputs}, 5'h05)
    // Interference bit with the interrupt unmasked
    apb(IRQ_MASK_OFS, 1'b1, 32'hf);
    `CHK(er, 1'b0)
    apb(IRQ_STAT_OFS, 1'b0, 32'h0);
    asi_master_model_i.param_call(2'b10);
    repeat (5) @(posedge clk_sys);
    `CHK(interferenceFlag, 1'b1)
    apb(LINK_OFS, 1'b0, 32'h0);
    `CHK(rd[LNK_INTERFERE], 1'b1)
    asi_master_model_i.disturb();
    @(negedge clk_sys);
    `CHK(interferenceFlag, 1'b0)
    repeat (2) @(posedge clk_sys);
    `CHK({irq, safetyOutputsEnable}, 2'b11)
    apb(IRQ_STAT_OFS, 1'b0, 32'h0);
    `CHK(rd[EV_INTERFERE], 1'b1)
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    // Masked event raises no interrupt
    apb(IRQ_MASK_OFS, 1'b1, 32'h0);
    asi_master_model_i.param_call(2'b10);
    asi_master_model_i.disturb();
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    // Refused accesses
    apb(8'h10, 1'b0, 32'h0);
    `CHK(er, 1'b1)
    apb(CONFIG_OFS, 1'b1, 32'hffffffff);
    `CHK(er, 1'b1)
    `CHK(cfg, ec)
    // Short and long restart delay
    check_delay(2'b10, SHORT);
    check_delay(2'b11, LONG);
    // Non-muting wiring: mode pin high, then bridged
    do_reset(7'b0001000);
    `CHK({nmCfg.fault, nmCfg.resOn}, 2'b01)
    `CHK(nmCfg.edmOn, 1'b1)
    `CHK(cfg.fault, 1'b1)
    do_reset(7'b0000100);
    `CHK({nmCfg.fault, nmCfg.resOn}, 2'b00)
    // Reset in mid-run clears the decode, then start-up runs again
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({cfg, safetyOutputsEnable, interferenceFlag}, {CONFIG_RST, 2'b00})
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({safetyOutputsEnable, restartDelayDone, irq}, 3'b000)
    repeat (10) @(posedge clk_sys);
    `CHK({nmCfg.fault, nmCfg.resOn}, 2'b00)
    finish_test();
  end
endmodule : safety_curtain_mode_strap_decoder_test
